// [core/pdc_defines.vh]
// Constants for the divider configuration word receiver.
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// =====================================================================
// Word layout
`define PDC_WORD_W          32
`define PDC_SEL_LSB         0
`define PDC_SEL_MSB         1
`define PDC_SEL_THIS_WORD   2'h0
`define PDC_REFDIV_LSB      2
`define PDC_REFDIV_MSB      11
`define PDC_FBDIV_LSB       12
`define PDC_FBDIV_MSB       23
`define PDC_REFDLY_LSB      24
`define PDC_REFDLY_MSB      26
`define PDC_FBDLY_LSB       27
`define PDC_FBDLY_MSB       29
`define PDC_AUTO_BIT        30
`define PDC_FDDIS_BIT       31

// =====================================================================
// Power-up values
`define PDC_REFDIV_RST      10'h07f
`define PDC_FBDIV_RST       12'h07f
`define PDC_DLY_RST         3'h0
`define PDC_BIT_RST         1'h0

// =====================================================================
// Pins and references
// Idle levels of power-down, latch-enable, data and link clock, in that order.
`define PDC_PIN_IDLE        4'he
`define PDC_NUM_REFS        2
`define PDC_PRI_IDX         0
`define PDC_SEC_IDX         1

// =====================================================================
// Timing
`define PDC_SYS_CLK_MHZ     125
`define PDC_REF_MIN_PER_NS  500
`define PDC_REF_GAP_CYCLES  ((`PDC_REF_MIN_PER_NS * `PDC_SYS_CLK_MHZ) / 1000)
`define PDC_GAP_CNT_W       7

`endif

// [core/pdc_ref_activity.v]
// Reference clock activity detector with its own input synchroniser.
`include "pdc_defines.vh"

module pdc_ref_activity
(
  input  wire i_sys_clk,
  input  wire i_rst_b,
  input  wire i_ref_clk,
  output reg  o_active_ff
);

  localparam integer              GAP_CYCLES = `PDC_REF_GAP_CYCLES;
  localparam [`PDC_GAP_CNT_W-1:0] GAP_MAX    = GAP_CYCLES[`PDC_GAP_CNT_W-1:0];

  reg                      meta_ff;
  reg                      sync_ff;
  reg                      prev_ff;
  reg [`PDC_GAP_CNT_W-1:0] gap_ff;
  reg [`PDC_GAP_CNT_W-1:0] nxt_gap;

  wire rise = sync_ff & ~prev_ff;

  // =====================================================================
  // A reference counts as present while rising edges come closer than
  // the slowest detectable period.
  always @*
  begin
    nxt_gap = gap_ff;
    if (rise)
    begin
      nxt_gap = {`PDC_GAP_CNT_W{1'b0}};
    end
    else if (gap_ff != GAP_MAX)
    begin
      nxt_gap = gap_ff + {{(`PDC_GAP_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_ff     <= 1'b0;
      sync_ff     <= 1'b0;
      prev_ff     <= 1'b0;
      gap_ff      <= GAP_MAX;
      o_active_ff <= 1'b0;
    end
    else
    begin
      meta_ff     <= i_ref_clk;
      sync_ff     <= meta_ff;
      prev_ff     <= sync_ff;
      gap_ff      <= nxt_gap;
      o_active_ff <= (nxt_gap != GAP_MAX);
    end
  end

endmodule

// [core/pdc_config_word.v]
// Serial write port and storage for the divider and reference config word.
`include "pdc_defines.vh"

module pdc_config_word
(
  input  wire        i_sys_clk,
  input  wire        i_rst_b,
  input  wire        i_serial_clk,
  input  wire        i_serial_data,
  input  wire        i_serial_latch_enable,
  input  wire        i_power_down_input_b,
  input  wire        i_primary_ref_clock,
  input  wire        i_secondary_ref_clock,
  input  wire        i_manual_select_secondary,
  output reg  [9:0]  o_ref_predivide_value_ff,
  output reg  [11:0] o_feedback_divide_value_ff,
  output reg  [2:0]  o_ref_phase_delay_ff,
  output reg  [2:0]  o_fb_phase_delay_ff,
  output reg         o_auto_ref_select_ff,
  output reg         o_freq_detect_disable_ff,
  output reg         o_use_secondary_ref_ff,
  output reg         o_ref_status_ff
);

  // =====================================================================
  // Pin synchronisers, two stages each.
  reg [3:0] meta_ff;
  reg [3:0] sync_ff;
  reg       clk_prev_ff;
  reg       le_prev_ff;

  wire sclk      = sync_ff[0];
  wire sdata     = sync_ff[1];
  wire sle       = sync_ff[2];
  wire pd_active = ~sync_ff[3];

  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      // Stages start at each pin's idle level.
      // A false latch-enable edge after reset would load an empty word.
      meta_ff     <= `PDC_PIN_IDLE;
      sync_ff     <= `PDC_PIN_IDLE;
      clk_prev_ff <= 1'b0;
      le_prev_ff  <= 1'b1;
    end
    else
    begin
      meta_ff     <= {i_power_down_input_b, i_serial_latch_enable, i_serial_data,
                      i_serial_clk};
      sync_ff     <= meta_ff;
      clk_prev_ff <= sclk;
      le_prev_ff  <= sle;
    end
  end

  // =====================================================================
  // Rising edges of the synchronised link clock and latch-enable.
  wire sclk_rise = sclk & ~clk_prev_ff;
  wire le_rise   = sle & ~le_prev_ff;

  // =====================================================================
  // Shift register, MSB first, only while latch-enable is low.
  // The last 32 bits shifted before latch-enable rises form the word.
  reg [`PDC_WORD_W-1:0] shift_ff;
  reg [`PDC_WORD_W-1:0] nxt_shift;

  always @*
  begin
    nxt_shift = shift_ff;
    if (sclk_rise && !sle && !pd_active)
    begin
      nxt_shift = {shift_ff[`PDC_WORD_W-2:0], sdata};
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      shift_ff <= {`PDC_WORD_W{1'b0}};
    end
    else
    begin
      shift_ff <= nxt_shift;
    end
  end

  // =====================================================================
  // Word select decode; words for the other registers pass unseen.
  function sel_hits;
    input [`PDC_WORD_W-1:0] w;
    begin
      sel_hits = (w[`PDC_SEL_MSB:`PDC_SEL_LSB] == `PDC_SEL_THIS_WORD);
    end
  endfunction

  wire load = le_rise && !pd_active && sel_hits(shift_ff);

  // =====================================================================
  // Word storage; no path returns data to the host.
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_ref_predivide_value_ff   <= `PDC_REFDIV_RST;
      o_feedback_divide_value_ff <= `PDC_FBDIV_RST;
      o_ref_phase_delay_ff       <= `PDC_DLY_RST;
      o_fb_phase_delay_ff        <= `PDC_DLY_RST;
      o_auto_ref_select_ff       <= `PDC_BIT_RST;
      o_freq_detect_disable_ff   <= `PDC_BIT_RST;
    end
    // Power-down outranks a load that falls in the same cycle.
    else if (pd_active)
    begin
      o_ref_predivide_value_ff   <= `PDC_REFDIV_RST;
      o_feedback_divide_value_ff <= `PDC_FBDIV_RST;
      o_ref_phase_delay_ff       <= `PDC_DLY_RST;
      o_fb_phase_delay_ff        <= `PDC_DLY_RST;
      o_auto_ref_select_ff       <= `PDC_BIT_RST;
      o_freq_detect_disable_ff   <= `PDC_BIT_RST;
    end
    else if (load)
    begin
      o_ref_predivide_value_ff   <= shift_ff[`PDC_REFDIV_MSB:`PDC_REFDIV_LSB];
      o_feedback_divide_value_ff <= shift_ff[`PDC_FBDIV_MSB:`PDC_FBDIV_LSB];
      o_ref_phase_delay_ff       <= shift_ff[`PDC_REFDLY_MSB:`PDC_REFDLY_LSB];
      o_fb_phase_delay_ff        <= shift_ff[`PDC_FBDLY_MSB:`PDC_FBDLY_LSB];
      o_auto_ref_select_ff       <= shift_ff[`PDC_AUTO_BIT];
      o_freq_detect_disable_ff   <= shift_ff[`PDC_FDDIS_BIT];
    end
  end

  // =====================================================================
  // Reference selection and status.
  wire [`PDC_NUM_REFS-1:0] ref_clk_in;
  wire [`PDC_NUM_REFS-1:0] ref_active;
  wire                     pri_active;
  wire                     sec_active;

  assign ref_clk_in[`PDC_PRI_IDX] = i_primary_ref_clock;
  assign ref_clk_in[`PDC_SEC_IDX] = i_secondary_ref_clock;
  assign pri_active               = ref_active[`PDC_PRI_IDX];
  assign sec_active               = ref_active[`PDC_SEC_IDX];

  // One activity detector per reference input.
  genvar g;
  generate
    for (g = 0; g < `PDC_NUM_REFS; g = g + 1)
    begin : g_ref
      pdc_ref_activity u_act
      (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_ref_clk   (ref_clk_in[g]),
        .o_active_ff (ref_active[g])
      );
    end
  endgenerate

  // The manual selection pin is synchronised like the link pins.
  reg man_meta_ff;
  reg man_sync_ff;
  reg nxt_use_sec;
  reg nxt_status;

  always @*
  begin
    nxt_use_sec = man_sync_ff;
    if (o_auto_ref_select_ff)
    begin
      // Automatic mode stays on primary while it runs, else falls to secondary if that one runs.
      nxt_use_sec = ~pri_active & sec_active;
    end
    // Status follows the selected reference unless detection is switched off.
    // During power-down the status pin is held low and the word is held at its power-up values.
    nxt_status = 1'b1;
    if (pd_active)
    begin
      nxt_status = 1'b0;
    end
    else if (!o_freq_detect_disable_ff)
    begin
      nxt_status = nxt_use_sec ? sec_active : pri_active;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      man_meta_ff            <= 1'b0;
      man_sync_ff            <= 1'b0;
      o_use_secondary_ref_ff <= 1'b0;
      o_ref_status_ff        <= 1'b0;
    end
    else
    begin
      man_meta_ff            <= i_manual_select_secondary;
      man_sync_ff            <= man_meta_ff;
      o_use_secondary_ref_ff <= nxt_use_sec;
      o_ref_status_ff        <= nxt_status;
    end
  end

endmodule

// [verification/pdc_host_model.sv]
// Host model that shifts configuration words into the serial port.
module pdc_host_model
(
  input  wire  i_sys_clk,
  output logic o_serial_clk = 1'b0,
  output logic o_serial_data = 1'b1,
  output logic o_serial_latch_enable = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sends a word with clock phases of hp cycles; the data line rests at its pull-up level.
  task automatic send(input logic [31:0] w, input int hp);
    o_serial_latch_enable = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      o_serial_data = w[i];
      repeat (hp) @(negedge i_sys_clk);
      o_serial_clk = 1'b1;
      repeat (hp) @(negedge i_sys_clk);
      o_serial_clk = 1'b0;
    end
    o_serial_data = 1'b1;
    repeat (hp) @(negedge i_sys_clk);
    o_serial_latch_enable = 1'b1;
    repeat (hp) @(negedge i_sys_clk);
  endtask
endmodule

// [verification/pdc_config_word_chk.sv]
// Assertion checker for the configuration word block.
module pdc_config_word_chk
(
  input wire        i_sys_clk,
  input wire        i_rst_b,
  input wire        i_serial_latch_enable,
  input wire        i_power_down_input_b,
  input wire        i_primary_ref_clock,
  input wire [9:0]  o_ref_predivide_value_ff,
  input wire [11:0] o_feedback_divide_value_ff,
  input wire [2:0]  o_ref_phase_delay_ff,
  input wire [2:0]  o_fb_phase_delay_ff,
  input wire        o_auto_ref_select_ff,
  input wire        o_freq_detect_disable_ff,
  input wire        o_use_secondary_ref_ff,
  input wire        o_ref_status_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [4:0]  le_ff, pd_ff;
  reg         pri_ff;
  reg  [6:0]  gap_ff;
  wire        pd = !i_power_down_input_b;
  wire        fdd = o_freq_detect_disable_ff;
  wire        load_ok = (le_ff[2] & ~le_ff[3]) | (le_ff[3] & ~le_ff[4]) | ~&pd_ff[3:1];
  wire [29:0] word = {fdd, o_auto_ref_select_ff, o_fb_phase_delay_ff, o_ref_phase_delay_ff,
                      o_feedback_divide_value_ff, o_ref_predivide_value_ff};
  always @(posedge i_sys_clk)
  begin
    le_ff <= {le_ff[3:0], i_serial_latch_enable};
    pd_ff <= {pd_ff[3:0], i_power_down_input_b};
    pri_ff <= i_primary_ref_clock;
    gap_ff <= (pri_ff != i_primary_ref_clock) ? 7'h0 : gap_ff + {6'h0, gap_ff != 7'h7f};
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_pd_refdiv: assert property (pd [*5] |-> word[9:0] == 10'h07f)
    else $error("refdiv not default");
  a_pd_fbdiv: assert property (pd [*5] |-> word[21:10] == 12'h07f)
    else $error("fbdiv not default");
  a_pd_delays: assert property (pd [*5] |-> word[27:22] == 6'h00)
    else $error("delays not zero");
  a_pd_mode_bits: assert property (pd [*5] |-> word[29:28] == 2'h0)
    else $error("mode bits not zero");
  a_pd_status_low: assert property (pd [*5] |-> !o_ref_status_ff)
    else $error("status high in power-down");
  a_off_status_high: assert property ((fdd && !pd) [*5] |-> o_ref_status_ff)
    else $error("status low with detect off");
  a_load_timing: assert property ($changed(word) |-> load_ok)
    else $error("word changed without load");
  a_loss_status: assert property
    ((gap_ff > 7'h48 && !fdd && !o_use_secondary_ref_ff) [*2] |-> !o_ref_status_ff)
    else $error("status high without reference");
  c_load: cover property ($changed(word));
  c_loss: cover property (gap_ff > 7'h48 && !o_ref_status_ff);
  c_off: cover property (fdd && o_ref_status_ff);
endmodule
bind pdc_config_word pdc_config_word_chk chk_u (.*);

// [verification/pdc_config_word_tb.sv]
// Self-checking bench for the divider configuration word block.
module pdc_config_word_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] def_word = 32'h0007f1fc;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_power_down_input_b = 1'b1, pri_run = 1'b1;
  logic i_primary_ref_clock = 1'b0, i_secondary_ref_clock = 1'b0, i_manual_select_secondary = 1'b0;
  logic [31:0] seed = 32'h61e9, exp_w = def_word;
  int err_count = 0, cmp_count = 0, cyc = 0;
  wire i_serial_clk, i_serial_data, i_serial_latch_enable, o_ref_status_ff;
  wire o_auto_ref_select_ff, o_freq_detect_disable_ff, o_use_secondary_ref_ff;
  wire [9:0] o_ref_predivide_value_ff;
  wire [11:0] o_feedback_divide_value_ff;
  wire [2:0] o_ref_phase_delay_ff, o_fb_phase_delay_ff;
  wire [29:0] fields = {o_freq_detect_disable_ff, o_auto_ref_select_ff, o_fb_phase_delay_ff,
    o_ref_phase_delay_ff, o_feedback_divide_value_ff, o_ref_predivide_value_ff};
  pdc_config_word dut_u (.*);
  pdc_host_model host_u (.i_sys_clk(i_sys_clk), .o_serial_clk(i_serial_clk),
    .o_serial_data(i_serial_data), .o_serial_latch_enable(i_serial_latch_enable));
  always #4 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk)
    if (cyc % 3 == 0) i_primary_ref_clock <= pri_run & ~i_primary_ref_clock;
  always @(negedge i_sys_clk)
    if (cyc % 4 == 0) i_secondary_ref_clock <= ~i_secondary_ref_clock;
  always @(posedge i_sys_clk)
    if (++cyc > 20000) complete_run(1);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] expect_word(input logic [31:0] cur, w);
    return (w[1:0] == 2'h0) ? w : cur;
  endfunction
  task automatic check(input logic [31:0] seen, exp, input string nm);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run(input int extra);
    err_count += extra;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic put(input logic [31:0] w, input int hp);
    host_u.send(w, hp);
    exp_w = expect_word(exp_w, w);
    repeat (6) @(negedge i_sys_clk);
    check(fields, exp_w >> 2, "word");
  endtask
  initial
  begin
    repeat (6) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    repeat (30) @(negedge i_sys_clk);
    check(fields, def_word >> 2, "defaults");
    check({31'h0, o_ref_status_ff}, 32'h1, "status_on");
    put(32'hfffffffc, 4);
    // The feedback routing lives in another word, so any divide value is legal here.
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      put({seed[31:2], i[1:0]}, 4);
    end
    $display("test words done");
    put(def_word, 4);
    pri_run = 1'b0;
    repeat (90) @(negedge i_sys_clk);
    check({31'h0, o_ref_status_ff}, 32'h0, "status_lost");
    put(32'h8007f1fc, 4);
    check({31'h0, o_ref_status_ff}, 32'h1, "status_forced");
    i_manual_select_secondary = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    check({31'h0, o_use_secondary_ref_ff}, 32'h1, "manual_sec");
    i_manual_select_secondary = 1'b0;
    put(32'h4007f1fc, 4);
    repeat (90) @(negedge i_sys_clk);
    check({30'h0, o_use_secondary_ref_ff, o_ref_status_ff}, 32'h3, "auto_sec");
    $display("test status done");
    i_power_down_input_b = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    check({1'b0, o_ref_status_ff, fields}, def_word >> 2, "power_down");
    i_power_down_input_b = 1'b1;
    pri_run = 1'b1;
    exp_w = def_word;
    repeat (4) @(negedge i_sys_clk);
    put(32'h2468ace0, 4);
    $display("test power_down done");
    complete_run(0);
  end
endmodule
